/* File: prag_map.svh */
// Constants for the paged read address generator
`ifndef PRAG_MAP_SVH
`define PRAG_MAP_SVH
`define PRAG_PAGE_RESET    10'h001
`define PRAG_PAGE_ZERO     10'h000
`define PRAG_PAGE_PS_MIN   10'h200
`define PRAG_PAGE_LSW_LAST 10'h2ff
`define PRAG_PAGE_MSB_FST  10'h300
`define PRAG_PAGE_LAST     10'h3ff
`define PRAG_PAGE_TOP_BIT  9
`define PRAG_EA_TOP_BIT    15
`endif

/* File: prag_pkg.sv */
// Types for the paged read address generator
package prag_pkg;
  typedef enum logic [3:0] {
    PRAG_MODE_PREPOST = 4'h1,
    PRAG_MODE_OFFSET  = 4'h2,
    PRAG_MODE_MODULO  = 4'h4,
    PRAG_MODE_BITREV  = 4'h8
  } prag_mode_e;

  typedef struct packed {
    logic [15:0] base_ea;
    logic [15:0] mod_ea;
    prag_mode_e  mode;
    logic        is_write;
  } prag_req_s;

  typedef struct packed {
    logic [23:0] addr;
    logic        paged;
    logic        to_prog;
    logic [15:0] ea;
  } prag_rsp_s;
endpackage : prag_pkg

/* File: prag_page_reg.sv */
// Page register holding the current read page
`include "prag_map.svh"
module prag_page_reg
  import prag_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sw_we,
  input  wire logic [9:0] sw_data,
  input  wire logic       step_en,
  input  wire logic [9:0] step_val,
  output logic      [9:0] page
);
  logic [9:0] next_page;

  // Software write wins over hardware stepping
  always_comb begin
    next_page = page;
    if (step_en) begin
      next_page = step_val;
    end
    if (sw_we) begin
      next_page = sw_data;
    end
  end

  // Page zero is never the reset value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      page <= `PRAG_PAGE_RESET;
    end else begin
      page <= next_page;
    end
  end
endmodule : prag_page_reg

/* File: prag_addr_gen.sv */
// Paged read address generator for the program space window
// Notes on behaviour
// - With page bit 9 and EA bit 15 set, address is page bits 8:0 joined above EA bits 14:0.
// - Each page is a 32-Kbyte window, spanning up to 16 Mbytes in total.
// - Pages 0x200 and up map to program space, which is read only through the window.
// - Crossing is detected for every in-window access, whatever the addressing mode.
// - A crossing shows as the modified EA having bit 15 cleared.
// - Overflow increments the page and forces EA bit 15 to one.
// - Underflow decrements the page and forces EA bit 15 to one.
// - Offset, modulo and bit-reversed crossings set EA bit 15 and keep the page.
// - Overflow from 0x2FF goes to 0x300, underflow from 0x300 goes to 0x2FF, bit 15 kept.
// - Overflow at 0x3FF or underflow at 0x001 or 0x200 keeps the page and clears bit 15.
// - An extended access with page zero raises an address error trap.
// - Only the pre/post-modify mode (PRAG_MODE_PREPOST) steps the page.
// - Reset loads the page with 0x001.
// - Base and modified EAs both with bit 15 clear go to data space whatever the page.
`include "prag_map.svh"
module prag_addr_gen
  import prag_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       page_we,
  input  wire logic [9:0] page_wdata,
  input  wire logic       req_valid,
  input  prag_req_s       req,
  output logic      [9:0] read_page_register,
  output logic            rsp_valid,
  output prag_rsp_s       rsp,
  output logic            addr_error_trap,
  output logic            write_refused
);
  logic       in_window;
  logic       crossed;
  logic       overflow;
  logic       underflow;
  logic       step_en;
  logic [9:0] step_val;
  logic [15:0] fix_ea;
  logic [9:0] use_page;
  prag_rsp_s  next_rsp;
  logic       next_rsp_valid;
  logic       next_trap;
  logic       next_refused;

  // Form a read address from page and effective address
  function automatic logic [23:0] join_addr(input logic [9:0] pg, input logic [15:0] ea);
    join_addr = {pg[8:0], ea[14:0]};
  endfunction : join_addr

  prag_page_reg u_page (
    .clk      (clk),
    .reset    (reset),
    .sw_we    (page_we),
    .sw_data  (page_wdata),
    .step_en  (step_en),
    .step_val (step_val),
    .page     (read_page_register)
  );

  // Crossing detection and page stepping decision
  always_comb begin
    in_window = req.base_ea[`PRAG_EA_TOP_BIT];
    crossed   = in_window && !req.mod_ea[`PRAG_EA_TOP_BIT];
    overflow  = crossed && (req.mod_ea[14:0] < req.base_ea[14:0]);
    underflow = crossed && !overflow;
    step_en   = 1'b0;
    step_val  = read_page_register;
    fix_ea    = req.mod_ea;
    if (req_valid && crossed) begin
      if (req.mode == PRAG_MODE_PREPOST) begin
        if (overflow) begin
          if (read_page_register == `PRAG_PAGE_LAST) begin
            fix_ea[`PRAG_EA_TOP_BIT] = 1'b0;
          end else begin
            step_en  = 1'b1;
            step_val = read_page_register + 10'h001;
            fix_ea[`PRAG_EA_TOP_BIT] = 1'b1;
          end
        end else begin
          if (read_page_register == `PRAG_PAGE_RESET ||
              read_page_register == `PRAG_PAGE_PS_MIN) begin
            fix_ea[`PRAG_EA_TOP_BIT] = 1'b0;
          end else begin
            step_en  = 1'b1;
            step_val = read_page_register - 10'h001;
            fix_ea[`PRAG_EA_TOP_BIT] = 1'b1;
          end
        end
      end else begin
        fix_ea[`PRAG_EA_TOP_BIT] = 1'b1;
      end
    end
  end

  // Translate the access; page steps apply to this access and, without a same-cycle software write, to the ones after it
  always_comb begin
    use_page       = step_en ? step_val : read_page_register;
    next_rsp_valid = req_valid;
    next_rsp.ea    = fix_ea;
    next_rsp.paged = fix_ea[`PRAG_EA_TOP_BIT];
    next_rsp.to_prog = next_rsp.paged && use_page[`PRAG_PAGE_TOP_BIT];
    next_rsp.addr  = next_rsp.paged ? join_addr(use_page, fix_ea) : {8'h00, fix_ea};
    next_trap      = req_valid && next_rsp.paged && (use_page == `PRAG_PAGE_ZERO);
    next_refused   = req_valid && next_rsp.to_prog && req.is_write;
  end

  // Registered answer, one cycle after the request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_valid       <= 1'b0;
      rsp             <= '0;
      addr_error_trap <= 1'b0;
      write_refused   <= 1'b0;
    end else begin
      rsp_valid       <= next_rsp_valid;
      rsp             <= next_rsp;
      addr_error_trap <= next_trap;
      write_refused   <= next_refused;
    end
  end

  // Overflow from the last lsw page lands on the first msb page
  lsw_to_msb_a : assert property (@(posedge clk) disable iff (reset)
    req_valid && req.mode == PRAG_MODE_PREPOST && overflow && !page_we &&
    read_page_register == `PRAG_PAGE_LSW_LAST |=> read_page_register == `PRAG_PAGE_MSB_FST)
    else $error("page did not advance to 0x300");

  // Underflow from first msb page returns to last lsw page
  msb_to_lsw_a : assert property (@(posedge clk) disable iff (reset)
    req_valid && req.mode == PRAG_MODE_PREPOST && underflow && !page_we &&
    read_page_register == `PRAG_PAGE_MSB_FST |=> read_page_register == `PRAG_PAGE_LSW_LAST)
    else $error("page did not step back to 0x2ff");

  // Other modes never move the page
  mode_keeps_page_a : assert property (@(posedge clk) disable iff (reset)
    req_valid && req.mode != PRAG_MODE_PREPOST && !page_we |=> $stable(read_page_register))
    else $error("page moved in non stepping mode");

  // Overflow at the last page falls into base data space
  edge_unpaged_a : assert property (@(posedge clk) disable iff (reset)
    req_valid && req.mode == PRAG_MODE_PREPOST && overflow &&
    read_page_register == `PRAG_PAGE_LAST |=> rsp_valid && !rsp.paged)
    else $error("overflow at last page stayed paged");

  // Page zero access traps
  page_zero_trap_a : assert property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp.paged && $past(read_page_register) == `PRAG_PAGE_ZERO &&
    !$past(step_en) |-> addr_error_trap)
    else $error("no trap for page zero access");

  // Lower half addresses ignore the page
  direct_data_a : assert property (@(posedge clk) disable iff (reset)
    req_valid && !req.base_ea[15] && !req.mod_ea[15] |=>
    rsp.addr == {8'h00, $past(req.mod_ea)} && !addr_error_trap)
    else $error("lower half address was paged");

  // Software write is seen by the following access
  sw_write_a : assert property (@(posedge clk) disable iff (reset)
    page_we |=> read_page_register == $past(page_wdata))
    else $error("page write lost");

  // Writes into program space are refused
  prog_write_a : assert property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp.to_prog |-> rsp.paged && !addr_error_trap &&
    (write_refused == $past(req.is_write)))
    else $error("program space write not refused");

  // Overflow inside the page range steps the page up
  page_step_up_a : assert property (@(posedge clk) disable iff (reset)
    req_valid && req.mode == PRAG_MODE_PREPOST && overflow && !page_we &&
    read_page_register != `PRAG_PAGE_LAST |=>
    read_page_register == $past(read_page_register) + 10'h001 && rsp.paged)
    else $error("page did not step up on overflow");

  // Underflow inside the page range steps the page down
  page_step_down_a : assert property (@(posedge clk) disable iff (reset)
    req_valid && req.mode == PRAG_MODE_PREPOST && underflow && !page_we &&
    read_page_register != `PRAG_PAGE_RESET && read_page_register != `PRAG_PAGE_PS_MIN |=>
    read_page_register == $past(read_page_register) - 10'h001 && rsp.paged)
    else $error("page did not step down on underflow");

  // Underflow at the lowest pages drops to base data space and keeps the page
  under_unpaged_a : assert property (@(posedge clk) disable iff (reset)
    req_valid && req.mode == PRAG_MODE_PREPOST && underflow && !page_we &&
    (read_page_register == `PRAG_PAGE_RESET || read_page_register == `PRAG_PAGE_PS_MIN) |=>
    rsp_valid && !rsp.paged && $stable(read_page_register))
    else $error("underflow at lowest page stayed paged");

  // Every request is answered on the next edge
  answer_next_a : assert property (@(posedge clk) disable iff (reset)
    req_valid |=> rsp_valid)
    else $error("request not answered");

  // No request, no answer and no side flags
  idle_quiet_a : assert property (@(posedge clk) disable iff (reset)
    !req_valid |=> !rsp_valid && !addr_error_trap && !write_refused)
    else $error("answer without request");

  // Paged answer joins the current page above the low EA bits
  window_join_a : assert property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp.paged && !$past(page_we) |->
    rsp.addr == {read_page_register[8:0], rsp.ea[14:0]})
    else $error("paged address not formed from page");

  // Unpaged answer is the plain base address with no trap
  lower_plain_a : assert property (@(posedge clk) disable iff (reset)
    rsp_valid && !rsp.paged |-> rsp.addr == {8'h00, rsp.ea} && !addr_error_trap)
    else $error("unpaged address carries page bits");

  // A trap only ever comes with a paged page-zero access
  trap_cause_a : assert property (@(posedge clk) disable iff (reset)
    addr_error_trap |-> rsp_valid && rsp.paged && rsp.addr[23:15] == 9'h000)
    else $error("trap without page zero access");

  // Only program space writes are refused
  refuse_cause_a : assert property (@(posedge clk) disable iff (reset)
    write_refused |-> rsp_valid && rsp.to_prog)
    else $error("refusal outside program space");

  // Outside the window or without a request the page holds
  page_hold_a : assert property (@(posedge clk) disable iff (reset)
    (!req_valid || !req.base_ea[`PRAG_EA_TOP_BIT]) && !page_we |=> $stable(read_page_register))
    else $error("page moved without an in-window request");

  // Offset style crossings stay paged with the low bits untouched
  wrap_in_page_a : assert property (@(posedge clk) disable iff (reset)
    req_valid && req.mode != PRAG_MODE_PREPOST && crossed |=>
    rsp.paged && rsp.ea[14:0] == $past(req.mod_ea[14:0]))
    else $error("offset crossing left the window");
endmodule : prag_addr_gen

/* File: prag_cpu_model.sv */
// Effective-address source model feeding the generator's request side
module prag_cpu_model
  import prag_pkg::*;
(
  output logic       req_valid,
  output prag_req_s  req,
  output logic       page_we,
  output logic [9:0] page_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet request side until the first call
  initial begin
    req_valid  = 1'b0;
    req        = '0;
    page_we    = 1'b0;
    page_wdata = 10'h000;
  end
  // Called just after a falling edge; values hold until the next call
  task automatic drive(logic we, logic [9:0] wd, logic v, logic [15:0] b, int s,
                       prag_mode_e m, logic w);
    page_we = we;
    page_wdata = wd;
    req_valid = v;
    // Idle request fields carry junk so a stale value can never pass
    if (v) begin
      req = '{b, b + 16'(s), m, w};
    end else begin
      req = ~req;
    end
  endtask : drive
endmodule : prag_cpu_model

/* File: tb_top.sv */
// Self-checking bench for the paged read address generator
module tb_top
  import prag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0;
  logic       reset = 1;
  logic       req_valid, page_we, rsp_valid, addr_error_trap, write_refused;
  logic       ev = 0, et, ew;
  logic [9:0] page_wdata, read_page_register;
  prag_req_s  req;
  prag_rsp_s  rsp, er;
  int         num_errors = 0, n_tests = 0, cyc = 0, page = 1;
  prag_mode_e modes[4] = '{PRAG_MODE_PREPOST, PRAG_MODE_OFFSET, PRAG_MODE_MODULO, PRAG_MODE_BITREV};
  int         bp[7] = '{'h2ff, 'h3ff, 'h150, 'h001, 'h200, 'h300, 'h250};
  always #2.5 clk = ~clk;
  prag_cpu_model cpu (.req_valid(req_valid), .req(req), .page_we(page_we),
                      .page_wdata(page_wdata));
  prag_addr_gen uut (.clk(clk), .reset(reset), .page_we(page_we), .page_wdata(page_wdata),
                     .req_valid(req_valid), .req(req), .read_page_register(read_page_register),
                     .rsp_valid(rsp_valid), .rsp(rsp), .addr_error_trap(addr_error_trap),
                     .write_refused(write_refused));
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic cmp(logic [23:0] g, logic [23:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // One cycle: check the last answer, issue the next, advance the model
  task automatic step(logic we, logic [9:0] wd, logic v, logic [15:0] b, int s,
                      prag_mode_e m, logic w);
    logic [15:0] mo;
    logic        cr, ov;
    cmp(24'(read_page_register), 24'(page));
    cmp(24'(rsp_valid), 24'(ev));
    if (ev) begin
      cmp(24'(rsp.ea), 24'(er.ea));
      cmp(24'({rsp.paged, rsp.to_prog}), 24'({er.paged, er.to_prog}));
      cmp(24'(addr_error_trap), 24'(et));
      cmp(24'(write_refused), 24'(ew));
      cmp(rsp.addr, er.addr);
    end
    cpu.drive(we, wd, v, b, s, m, w);
    mo = b + 16'(s);
    ev = v;
    er = '0;
    er.ea = mo;
    cr = v && b[15] && !mo[15];
    ov = mo[14:0] < b[14:0];
    if (cr && m != PRAG_MODE_PREPOST) begin
      er.ea[15] = 1'b1;
    end else if (cr && ov && page != 'h3ff) begin
      page++;
      er.ea[15] = 1'b1;
    end else if (cr && !ov && page != 'h001 && page != 'h200) begin
      page--;
      er.ea[15] = 1'b1;
    end
    er.paged = er.ea[15];
    er.to_prog = page[9] && er.paged;
    er.addr = er.paged ? {page[8:0], er.ea[14:0]} : 24'(er.ea);
    et = er.paged && page == 0;
    ew = w && er.to_prog;
    // Software write wins over a step and is used from the next access
    if (we) page = wd;
    @(negedge clk);
  endtask : step
  // Cycle ceiling well above the planned run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    logic [15:0] b;
    logic        we;
    void'($urandom(78));
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset = 0;
    // Boundary pages: first three overflow, the rest underflow
    foreach (bp[i]) begin
      step(1, 10'(bp[i]), 0, 0, 0, PRAG_MODE_PREPOST, 0);
      step(0, 0, 1, i < 3 ? 16'hfff8 : 16'h8004, i < 3 ? 16 : -16, PRAG_MODE_PREPOST, 0);
    end
    foreach (modes[i]) step(0, 0, 1, 16'hfffc, 8, modes[i], 0);
    step(1, 0, 0, 0, 0, PRAG_MODE_PREPOST, 0);
    step(0, 0, 1, 16'h9000, 0, PRAG_MODE_OFFSET, 0);
    step(0, 0, 1, 16'h1000, 0, PRAG_MODE_PREPOST, 0);
    step(1, 10'h200, 0, 0, 0, PRAG_MODE_PREPOST, 0);
    step(0, 0, 1, 16'h9000, 2, PRAG_MODE_PREPOST, 1);
    // Back-to-back random traffic near both window edges
    repeat (400) begin
      we = $urandom % 8 == 0;
      b = ($urandom % 2) ? 16'h8000 : 16'hfff0;
      b = (b + 16'($urandom % 16)) ^ (($urandom % 4 == 0) ? 16'h8000 : 16'h0000);
      step(we, 10'($urandom % 'h3ff + 1), 1'($urandom % 4 != 0), b, int'($urandom % 33) - 16,
           modes[$urandom % 4], 1'($urandom));
    end
    step(0, 0, 0, 0, 0, PRAG_MODE_PREPOST, 0);
    summarize();
  end
endmodule : tb_top
